// *** common/utam_pkg.sv ***
// Constants, encodings and state type shared by the serial-to-memory tester.
// Assumes a single 25 MHz clock and an AXI slave with 64-bit data.
// Operation
// - Serial link runs 8N1 at a fixed 115200 baud.
// - Single command issues one AXI beat of eight bytes.
// - Single write takes address then 64-bit word and writes it.
// - Single read takes address, reads one word, returns it serially.
// - Burst command runs sixteen AXI bursts of sixteen beats, 2048 bytes.
// - Burst write stores initial word, then increments by one each 8-byte step.
// - Burst read fetches 2048 consecutive bytes and returns all of them.
package utam_pkg;
    localparam int          UTAM_CLK_HZ    = 25000000;
    localparam int          UTAM_BAUD      = 115200;
    localparam logic [7:0]  UTAM_BIT_CYC   = 8'(UTAM_CLK_HZ / UTAM_BAUD);
    localparam logic [7:0]  UTAM_HALF_CYC  = 8'(UTAM_CLK_HZ / UTAM_BAUD / 2);
    localparam logic [3:0]  UTAM_STOP_IDX  = 4'h9;
    localparam logic [3:0]  UTAM_DATA_IDX  = 4'h8;
    localparam logic [9:0]  UTAM_TX_IDLE   = 10'h3ff;

    // Opcode byte: bit 0 selects write, bit 1 selects burst, other bits zero.
    localparam int          UTAM_OP_WR_BIT = 0;
    localparam int          UTAM_OP_BU_BIT = 1;
    localparam logic [5:0]  UTAM_OP_ZERO   = 6'h00;
    localparam logic [7:0]  UTAM_ACK_BYTE  = 8'h06;
    localparam logic [7:0]  UTAM_NAK_BYTE  = 8'h15;

    localparam logic [3:0]  UTAM_ADDR_LAST = 4'h3;
    localparam logic [3:0]  UTAM_DATA_LAST = 4'h7;
    localparam logic [3:0]  UTAM_BEAT_BURST = 4'hf;
    localparam logic [3:0]  UTAM_BEAT_SINGLE = 4'h0;
    localparam logic [3:0]  UTAM_BURST_LAST = 4'hf;
    localparam logic [31:0] UTAM_BURST_BYTES = 32'h0000_0080;
    localparam logic [63:0] UTAM_DATA_STEP = 64'h0000_0000_0000_0001;
    localparam logic [2:0]  UTAM_AXI_SIZE8 = 3'h3;
    localparam logic [1:0]  UTAM_AXI_INCR  = 2'h1;
    localparam logic [1:0]  UTAM_AXI_OKAY  = 2'h0;
    localparam logic [7:0]  UTAM_AXI_STRB  = 8'hff;

    typedef enum logic [3:0] {
        UTAM_IDLE, UTAM_ADDR, UTAM_DATA, UTAM_AW, UTAM_W, UTAM_B,
        UTAM_ACK, UTAM_AR, UTAM_R, UTAM_TX
    } utam_state_e;
endpackage

// *** common/utam_uart_if.sv ***
// Byte stream between the serial engine and the command core.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`default_nettype none
interface utam_uart_if;
    logic       rx_valid;
    logic [7:0] rx_data;
    logic       tx_valid;
    logic       tx_ready;
    logic [7:0] tx_data;
    modport serial (output rx_valid, output rx_data, input tx_valid, output tx_ready, input tx_data);
    modport core   (input rx_valid, input rx_data, output tx_valid, input tx_ready, output tx_data);
endinterface
`default_nettype wire

// *** core/utam_top.sv ***
// Command core: decodes serial commands and runs them as AXI transactions.
// Assumes an AXI slave with 64-bit data that honours INCR bursts and rready back-pressure.
`timescale 1ns/100ps
`default_nettype none
module utam_top (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        uart_rx_i,
    output logic             uart_tx_o,
    output logic [31:0]      m_axi_awaddr_o,
    output logic [7:0]       m_axi_awlen_o,
    output logic [2:0]       m_axi_awsize_o,
    output logic [1:0]       m_axi_awburst_o,
    output logic             m_axi_awvalid_o,
    input  wire logic        m_axi_awready_i,
    output logic [63:0]      m_axi_wdata_o,
    output logic [7:0]       m_axi_wstrb_o,
    output logic             m_axi_wlast_o,
    output logic             m_axi_wvalid_o,
    input  wire logic        m_axi_wready_i,
    input  wire logic [1:0]  m_axi_bresp_i,
    input  wire logic        m_axi_bvalid_i,
    output logic             m_axi_bready_o,
    output logic [31:0]      m_axi_araddr_o,
    output logic [7:0]       m_axi_arlen_o,
    output logic [2:0]       m_axi_arsize_o,
    output logic [1:0]       m_axi_arburst_o,
    output logic             m_axi_arvalid_o,
    input  wire logic        m_axi_arready_i,
    input  wire logic [63:0] m_axi_rdata_i,
    input  wire logic [1:0]  m_axi_rresp_i,
    input  wire logic        m_axi_rlast_i,
    input  wire logic        m_axi_rvalid_i,
    output logic             m_axi_rready_o
);
    typedef struct packed {
        utam_pkg::utam_state_e st;
        logic                  opw;
        logic                  opb;
        logic                  err;
        logic                  lastb;
        logic [31:0]           addr;
        logic [63:0]           data;
        logic [63:0]           sh;
        logic [3:0]            cnt;
        logic [3:0]            beat;
        logic [3:0]            nburst;
    } utam_core_s;

    localparam utam_core_s RST = '{st: utam_pkg::UTAM_IDLE, default: '0};

    utam_core_s q, d;
    logic [3:0] last_beat;
    logic       last_burst;
    utam_uart_if uif ();

    utam_uart u_uart (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .rx_i    (uart_rx_i),
        .tx_o    (uart_tx_o),
        .bus     (uif.serial)
    );

    // Single commands move one beat, burst commands sixteen per burst.
    assign last_beat  = q.opb ? utam_pkg::UTAM_BEAT_BURST : utam_pkg::UTAM_BEAT_SINGLE;
    assign last_burst = !q.opb || (q.nburst == utam_pkg::UTAM_BURST_LAST);

    // ----------------------------------------------------------------
    // Command sequencer
    // ----------------------------------------------------------------
    always_comb begin
        d = q;
        case (q.st)
            utam_pkg::UTAM_IDLE: begin
                // Opcodes with stray high bits are ignored so a desynchronised host cannot start a burst.
                if (uif.rx_valid && uif.rx_data[7:2] == utam_pkg::UTAM_OP_ZERO) begin
                    d.opw = uif.rx_data[utam_pkg::UTAM_OP_WR_BIT];
                    d.opb = uif.rx_data[utam_pkg::UTAM_OP_BU_BIT];
                    d.cnt = 4'h0;
                    d.err = 1'b0;
                    d.st  = utam_pkg::UTAM_ADDR;
                end
            end
            utam_pkg::UTAM_ADDR: begin
                if (uif.rx_valid) begin
                    d.addr = {q.addr[23:0], uif.rx_data};
                    d.cnt  = q.cnt + 4'h1;
                    if (q.cnt == utam_pkg::UTAM_ADDR_LAST) begin
                        d.cnt    = 4'h0;
                        d.nburst = 4'h0;
                        d.st     = q.opw ? utam_pkg::UTAM_DATA : utam_pkg::UTAM_AR;
                    end
                end
            end
            utam_pkg::UTAM_DATA: begin
                if (uif.rx_valid) begin
                    d.data = {q.data[55:0], uif.rx_data};
                    d.cnt  = q.cnt + 4'h1;
                    if (q.cnt == utam_pkg::UTAM_DATA_LAST) begin
                        d.st = utam_pkg::UTAM_AW;
                    end
                end
            end
            utam_pkg::UTAM_AW: begin
                if (m_axi_awready_i) begin
                    d.beat = 4'h0;
                    d.st   = utam_pkg::UTAM_W;
                end
            end
            utam_pkg::UTAM_W: begin
                if (m_axi_wready_i) begin
                    // Pattern continues across bursts, giving 256 consecutive values.
                    d.data = q.data + utam_pkg::UTAM_DATA_STEP;
                    d.beat = q.beat + 4'h1;
                    if (q.beat == last_beat) begin
                        d.st = utam_pkg::UTAM_B;
                    end
                end
            end
            utam_pkg::UTAM_B: begin
                if (m_axi_bvalid_i) begin
                    d.err = q.err || (m_axi_bresp_i != utam_pkg::UTAM_AXI_OKAY);
                    if (last_burst) begin
                        d.st = utam_pkg::UTAM_ACK;
                    end else begin
                        d.nburst = q.nburst + 4'h1;
                        d.addr   = q.addr + utam_pkg::UTAM_BURST_BYTES;
                        d.st     = utam_pkg::UTAM_AW;
                    end
                end
            end
            utam_pkg::UTAM_ACK: begin
                if (uif.tx_ready) begin
                    d.st = utam_pkg::UTAM_IDLE;
                end
            end
            utam_pkg::UTAM_AR: begin
                if (m_axi_arready_i) begin
                    d.beat = 4'h0;
                    d.st   = utam_pkg::UTAM_R;
                end
            end
            utam_pkg::UTAM_R: begin
                // Only one beat is held; rready stays low while it drains over the slow link.
                if (m_axi_rvalid_i) begin
                    d.sh    = m_axi_rdata_i;
                    d.lastb = (q.beat == last_beat);
                    d.beat  = q.beat + 4'h1;
                    d.cnt   = 4'h0;
                    d.st    = utam_pkg::UTAM_TX;
                end
            end
            utam_pkg::UTAM_TX: begin
                if (uif.tx_ready) begin
                    d.sh  = {q.sh[55:0], 8'h00};
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == utam_pkg::UTAM_DATA_LAST) begin
                        if (!q.lastb) begin
                            d.st = utam_pkg::UTAM_R;
                        end else if (last_burst) begin
                            d.st = utam_pkg::UTAM_IDLE;
                        end else begin
                            d.nburst = q.nburst + 4'h1;
                            d.addr   = q.addr + utam_pkg::UTAM_BURST_BYTES;
                            d.st     = utam_pkg::UTAM_AR;
                        end
                    end
                end
            end
            default: begin
                d.st = utam_pkg::UTAM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign uif.tx_valid    = (q.st == utam_pkg::UTAM_ACK) || (q.st == utam_pkg::UTAM_TX);
    assign uif.tx_data     = (q.st == utam_pkg::UTAM_TX) ? q.sh[63:56] :
                             (q.err ? utam_pkg::UTAM_NAK_BYTE : utam_pkg::UTAM_ACK_BYTE);

    assign m_axi_awaddr_o  = q.addr;
    assign m_axi_awlen_o   = {4'h0, last_beat};
    assign m_axi_awsize_o  = utam_pkg::UTAM_AXI_SIZE8;
    assign m_axi_awburst_o = utam_pkg::UTAM_AXI_INCR;
    assign m_axi_awvalid_o = (q.st == utam_pkg::UTAM_AW);
    assign m_axi_wdata_o   = q.data;
    assign m_axi_wstrb_o   = utam_pkg::UTAM_AXI_STRB;
    assign m_axi_wlast_o   = (q.st == utam_pkg::UTAM_W) && (q.beat == last_beat);
    assign m_axi_wvalid_o  = (q.st == utam_pkg::UTAM_W);
    assign m_axi_bready_o  = (q.st == utam_pkg::UTAM_B);
    assign m_axi_araddr_o  = q.addr;
    assign m_axi_arlen_o   = {4'h0, last_beat};
    assign m_axi_arsize_o  = utam_pkg::UTAM_AXI_SIZE8;
    assign m_axi_arburst_o = utam_pkg::UTAM_AXI_INCR;
    assign m_axi_arvalid_o = (q.st == utam_pkg::UTAM_AR);
    assign m_axi_rready_o  = (q.st == utam_pkg::UTAM_R);
endmodule // utam_top
`default_nettype wire

// *** core/utam_uart.sv ***
// Serial receiver and transmitter, 8 data bits, no parity, one stop bit.
// Assumes rx_i is asynchronous to clk_i; the core drains received bytes at once.
`timescale 1ns/100ps
`default_nettype none
module utam_uart (
    input  wire logic  clk_i,
    input  wire logic  rst_n_i,
    input  wire logic  rx_i,
    output logic       tx_o,
    utam_uart_if.serial bus
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic       rx_busy;
        logic [7:0] rx_div;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic       rx_v;
        logic [7:0] rx_byte;
        logic       tx_busy;
        logic [7:0] tx_div;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
    } utam_uart_s;

    localparam utam_uart_s RST = '{s1: 1'b1, s2: 1'b1, tx_sh: utam_pkg::UTAM_TX_IDLE, default: '0};

    utam_uart_s q, d;

    // ----------------------------------------------------------------
    // Bit timing
    // ----------------------------------------------------------------
    always_comb begin
        d      = q;
        d.s1   = rx_i;
        d.s2   = q.s1;
        d.rx_v = 1'b0;
        // Receiver samples mid-bit; a start bit that is gone at its middle is a glitch.
        if (!q.rx_busy) begin
            if (!q.s2) begin
                d.rx_busy = 1'b1;
                d.rx_div  = utam_pkg::UTAM_HALF_CYC - 8'h01;
                d.rx_bit  = 4'h0;
            end
        end else if (q.rx_div != 8'h00) begin
            d.rx_div = q.rx_div - 8'h01;
        end else begin
            d.rx_div = utam_pkg::UTAM_BIT_CYC - 8'h01;
            if (q.rx_bit == 4'h0) begin
                if (q.s2) begin
                    d.rx_busy = 1'b0;
                end else begin
                    d.rx_bit = 4'h1;
                end
            end else if (q.rx_bit <= utam_pkg::UTAM_DATA_IDX) begin
                d.rx_sh  = {q.s2, q.rx_sh[7:1]};
                d.rx_bit = q.rx_bit + 4'h1;
            end else begin
                d.rx_busy = 1'b0;
                // A byte with a broken stop bit is dropped.
                if (q.s2) begin
                    d.rx_v    = 1'b1;
                    d.rx_byte = q.rx_sh;
                end
            end
        end
        // Transmitter shifts start, data LSB first, stop.
        if (!q.tx_busy) begin
            if (bus.tx_valid) begin
                d.tx_busy = 1'b1;
                d.tx_sh   = {1'b1, bus.tx_data, 1'b0};
                d.tx_div  = utam_pkg::UTAM_BIT_CYC - 8'h01;
                d.tx_bit  = 4'h0;
            end
        end else if (q.tx_div != 8'h00) begin
            d.tx_div = q.tx_div - 8'h01;
        end else begin
            d.tx_div = utam_pkg::UTAM_BIT_CYC - 8'h01;
            d.tx_sh  = {1'b1, q.tx_sh[9:1]};
            if (q.tx_bit == utam_pkg::UTAM_STOP_IDX) begin
                d.tx_busy = 1'b0;
            end else begin
                d.tx_bit = q.tx_bit + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= RST;
        end else begin
            q <= d;
        end
    end

    assign tx_o         = q.tx_sh[0];
    assign bus.rx_valid = q.rx_v;
    assign bus.rx_data  = q.rx_byte;
    assign bus.tx_ready = !q.tx_busy;
endmodule // utam_uart
`default_nettype wire

// *** verification/test_uart_to_axi_memory_tester.sv ***
// Self-checking bench: host serial commands in, AXI memory model behind.
// Assumes the design and memory model share one 25 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module test_uart_to_axi_memory_tester;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, rx = 1'b1;
    logic        tx, awv, awr, wlast, wv, wr, bv, bready, arv, arr, rlast, rv, rr;
    logic [2:0]  stall = 3'h0;
    logic [1:0]  bresp, rresp;
    logic [7:0]  awlen, arlen, b;
    logic [31:0] awaddr, araddr, rnd, base, sadr;
    logic [63:0] wdata, rdata, init, swd, w;
    logic [7:0]  k;
    int          bad_count = 0, compares = 0;
    utam_top i_dut (.clk_i, .rst_n_i, .uart_rx_i(rx), .uart_tx_o(tx), .m_axi_awaddr_o(awaddr),
        .m_axi_awlen_o(awlen), .m_axi_awsize_o(), .m_axi_awburst_o(), .m_axi_awvalid_o(awv),
        .m_axi_awready_i(awr), .m_axi_wdata_o(wdata), .m_axi_wstrb_o(), .m_axi_wlast_o(wlast),
        .m_axi_wvalid_o(wv), .m_axi_wready_i(wr), .m_axi_bresp_i(bresp), .m_axi_bvalid_i(bv),
        .m_axi_bready_o(bready), .m_axi_araddr_o(araddr), .m_axi_arlen_o(arlen), .m_axi_arsize_o(),
        .m_axi_arburst_o(), .m_axi_arvalid_o(arv), .m_axi_arready_i(arr), .m_axi_rdata_i(rdata),
        .m_axi_rresp_i(rresp), .m_axi_rlast_i(rlast), .m_axi_rvalid_i(rv), .m_axi_rready_o(rr));
    utam_axi_mem i_mem (.clk_i, .rst_n_i, .stall_i(stall), .awaddr_i(awaddr), .awvalid_i(awv),
        .awready_o(awr), .wdata_i(wdata), .wlast_i(wlast), .wvalid_i(wv), .wready_o(wr), .bresp_o(bresp),
        .bvalid_o(bv), .bready_i(bready), .araddr_i(araddr), .arlen_i(arlen), .arvalid_i(arv),
        .arready_o(arr), .rdata_o(rdata), .rresp_o(rresp), .rlast_o(rlast), .rvalid_o(rv), .rready_i(rr));
    initial forever #20 clk_i = ~clk_i;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [63:0] exp_word(input logic [63:0] first, input int n);
        return first + 64'(n);
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ----------------------------------------
    // Host serial side, 8N1, least significant bit first
    // ----------------------------------------
    task automatic put_byte(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rx = f[i];
            repeat (utam_pkg::UTAM_BIT_CYC) @(posedge clk_i);
            #1;
        end
    endtask
    task automatic get_byte(output logic [7:0] d);
        // The line is sampled on falling edges, where the registered output has settled.
        while (tx !== 1'b0) @(negedge clk_i);
        repeat (utam_pkg::UTAM_HALF_CYC) @(negedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (utam_pkg::UTAM_BIT_CYC) @(negedge clk_i);
            d[i] = tx;
        end
        repeat (utam_pkg::UTAM_BIT_CYC) @(negedge clk_i);
        check(64'(tx), 64'h1);
        #1;
    endtask
    // The reply may start inside the last stop bit, so listening runs beside sending.
    task automatic xfer(input logic [7:0] op, input logic [31:0] a, input logic [63:0] d, input int n);
        w = 64'h0;
        fork
            begin
                put_byte(op);
                for (int i = 3; i >= 0; i--) put_byte(a[8*i +: 8]);
                if (op[0]) for (int i = 7; i >= 0; i--) put_byte(d[8*i +: 8]);
            end
            for (int j = 0; j < n; j++) begin
                get_byte(b);
                w = {w[55:0], b};
            end
        join
    endtask
    always @(posedge clk_i) begin
        #1;
        rnd = lfsr(rnd);
        stall <= rnd[2:0] & rnd[5:3];
    end
    initial begin
        // About 104k cycles of serial traffic are expected; a full burst read reply is never awaited.
        repeat (115000) @(posedge clk_i);
        bad_count++;
        test_done();
    end
    initial begin
        rnd  = lfsr(32'hbf181898);
        base = rnd & 32'h03ff_e000;
        rnd  = lfsr(rnd);
        init = {rnd, 32'hffff_ff80};
        rnd  = lfsr(rnd);
        sadr = base + 32'h1000 + (rnd & 32'h0000_07f8);
        swd  = {rnd, ~rnd};
        k    = rnd[15:8];
        repeat (6) @(posedge clk_i);
        #1;
        rst_n_i = 1'b1;
        put_byte(8'hfc);
        repeat (300) @(posedge clk_i);
        check(64'({tx, awv, arv}), 64'h4);
        $display("bad opcode test done");
        xfer(8'h03, base, init, 1);
        check(w, 64'(utam_pkg::UTAM_ACK_BYTE));
        for (int n = 0; n < 256; n++) check(i_mem.mem[11'(base[13:3] + n)], exp_word(init, n));
        $display("burst write test done");
        xfer(8'h01, sadr, swd, 1);
        check(w, 64'(utam_pkg::UTAM_ACK_BYTE));
        check(i_mem.mem[sadr[13:3]], swd);
        $display("single write test done");
        xfer(8'h00, base + {21'h0, k, 3'h0}, 64'h0, 8);
        check(w, exp_word(init, int'(k)));
        $display("single read test done");
        // The address phase is caught at its handshake, since it ends before the last byte is sent.
        fork
            xfer(8'h02, base, 64'h0, 1);
            begin
                while (arv !== 1'b1 || arr !== 1'b1) @(negedge clk_i);
                check({24'h0, arlen, araddr}, {24'h0, 8'h0f, base});
            end
        join
        check(w, exp_word(init, 0) >> 56);
        $display("burst read test done");
        test_done();
    end
endmodule // test_uart_to_axi_memory_tester
`default_nettype wire

// *** verification/utam_axi_mem.sv ***
// Behavioural AXI memory slave, 2048 words of 64 bits, address bits 13:3.
// Assumes one transaction at a time; stall_i bits hold off aw, w and ar ready.
`timescale 1ns/100ps
`default_nettype none
module utam_axi_mem (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  stall_i,
    input  wire logic [31:0] awaddr_i,
    input  wire logic        awvalid_i,
    output logic             awready_o,
    input  wire logic [63:0] wdata_i,
    input  wire logic        wlast_i,
    input  wire logic        wvalid_i,
    output logic             wready_o,
    output logic [1:0]       bresp_o,
    output logic             bvalid_o,
    input  wire logic        bready_i,
    input  wire logic [31:0] araddr_i,
    input  wire logic [7:0]  arlen_i,
    input  wire logic        arvalid_i,
    output logic             arready_o,
    output logic [63:0]      rdata_o,
    output logic [1:0]       rresp_o,
    output logic             rlast_o,
    output logic             rvalid_o,
    input  wire logic        rready_i
);
    logic [63:0] mem [0:2047];
    logic [31:0] wa_q;
    logic [31:0] ra_q;
    logic [7:0]  left_q;
    assign awready_o = !stall_i[0];
    assign wready_o  = !stall_i[1];
    assign arready_o = !stall_i[2] && !rvalid_o;
    assign bresp_o   = 2'h0;
    assign rresp_o   = 2'h0;
    assign rlast_o   = rvalid_o && left_q == 8'h00;
    // Idle read data toggles so a stale word is never mistaken for a fresh one.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_o <= 1'b0;
            rvalid_o <= 1'b0;
            rdata_o  <= 64'h0;
        end else begin
            if (awvalid_i && awready_o) wa_q <= awaddr_i;
            if (wvalid_i && wready_o) begin
                mem[wa_q[13:3]] <= wdata_i;
                wa_q <= wa_q + 32'h8;
                if (wlast_i) bvalid_o <= 1'b1;
            end
            if (bvalid_o && bready_i) bvalid_o <= 1'b0;
            if (arvalid_i && arready_o) begin
                ra_q     <= araddr_i;
                left_q   <= arlen_i;
                rvalid_o <= 1'b1;
                rdata_o  <= mem[araddr_i[13:3]];
            end else if (rvalid_o && rready_i && left_q != 8'h00) begin
                ra_q    <= ra_q + 32'h8;
                left_q  <= left_q - 8'h01;
                rdata_o <= mem[ra_q[13:3] + 11'h1];
            end else if (rvalid_o && rready_i) begin
                rvalid_o <= 1'b0;
                rdata_o  <= ~rdata_o;
            end else if (!rvalid_o) begin
                rdata_o <= ~rdata_o;
            end
        end
    end
endmodule // utam_axi_mem
`default_nettype wire

// *** verification/utam_checker.sv ***
// Assertions on the AXI master side of the serial-to-memory tester.
// Assumes one clock domain; sees only the ports of the top module.
`timescale 1ns/100ps
`default_nettype none
module utam_checker (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [31:0] m_axi_awaddr_o,
    input wire logic [7:0]  m_axi_awlen_o,
    input wire logic [2:0]  m_axi_awsize_o,
    input wire logic [1:0]  m_axi_awburst_o,
    input wire logic [7:0]  m_axi_wstrb_o,
    input wire logic        m_axi_awvalid_o,
    input wire logic        m_axi_awready_i,
    input wire logic [63:0] m_axi_wdata_o,
    input wire logic        m_axi_wlast_o,
    input wire logic        m_axi_wvalid_o,
    input wire logic        m_axi_wready_i,
    input wire logic        m_axi_bready_o,
    input wire logic [31:0] m_axi_araddr_o,
    input wire logic [7:0]  m_axi_arlen_o,
    input wire logic [2:0]  m_axi_arsize_o,
    input wire logic [1:0]  m_axi_arburst_o,
    input wire logic        m_axi_arvalid_o,
    input wire logic        m_axi_arready_i,
    input wire logic        m_axi_rvalid_i,
    input wire logic        m_axi_rready_o
);
    // ----------------------------------------
    // Beat and burst bookkeeping
    // ----------------------------------------
    logic [7:0]  beat_q;
    logic [3:0]  aw_cnt_q;
    logic [31:0] aw_last_q;
    logic [63:0] wd_q;
    wire         aw_hs = m_axi_awvalid_o && m_axi_awready_i;
    wire         w_hs  = m_axi_wvalid_o && m_axi_wready_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            beat_q    <= 8'h00;
            aw_cnt_q  <= 4'h0;
            aw_last_q <= 32'h0;
            wd_q      <= 64'h0;
        end else begin
            if (aw_hs) begin
                beat_q    <= 8'h00;
                aw_last_q <= m_axi_awaddr_o;
                aw_cnt_q  <= aw_cnt_q + 4'(m_axi_awlen_o == 8'h0f);
            end else if (w_hs) begin
                beat_q <= beat_q + 8'h01;
            end
            if (w_hs) begin
                wd_q <= m_axi_wdata_o;
            end
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    a_aw_shape: assert property (
        m_axi_awvalid_o |-> m_axi_awsize_o == 3'h3 && m_axi_awburst_o == 2'h1 &&
            (m_axi_awlen_o == 8'h00 || m_axi_awlen_o == 8'h0f))
        else $error("write burst shape wrong");
    a_w_strobe: assert property (
        m_axi_wvalid_o |-> m_axi_wstrb_o == 8'hff)
        else $error("write strobes not all set");
    a_aw_hold: assert property (
        m_axi_awvalid_o && !m_axi_awready_i |=> m_axi_awvalid_o && $stable(m_axi_awaddr_o))
        else $error("write address dropped before accept");
    a_aw_step: assert property (
        $rose(m_axi_awvalid_o) && aw_cnt_q != 4'h0 |-> m_axi_awaddr_o == aw_last_q + 32'h80)
        else $error("burst address step wrong");
    a_w_last: assert property (
        m_axi_wvalid_o |-> m_axi_wlast_o == (beat_q == m_axi_awlen_o))
        else $error("last beat flag misplaced");
    a_w_step: assert property (
        w_hs && beat_q != 8'h00 |-> m_axi_wdata_o == wd_q + 64'h1)
        else $error("burst data not incrementing");
    a_b_after: assert property (
        w_hs && m_axi_wlast_o |=> m_axi_bready_o)
        else $error("response not awaited after last beat");
    a_ar_shape: assert property (
        m_axi_arvalid_o |-> m_axi_arsize_o == 3'h3 && m_axi_arburst_o == 2'h1 &&
            (m_axi_arlen_o == 8'h00 || m_axi_arlen_o == 8'h0f))
        else $error("read burst length wrong");
    a_ar_hold: assert property (
        m_axi_arvalid_o && !m_axi_arready_i |=> m_axi_arvalid_o && $stable(m_axi_araddr_o))
        else $error("read address dropped before accept");
    a_r_gap: assert property (
        m_axi_rvalid_i && m_axi_rready_o |=> !m_axi_rready_o [*8])
        else $error("read beat taken before reply sent");
endmodule // utam_checker
bind utam_top utam_checker i_chk (.clk_i, .rst_n_i, .m_axi_awaddr_o, .m_axi_awlen_o, .m_axi_awsize_o,
    .m_axi_awburst_o, .m_axi_wstrb_o, .m_axi_arsize_o, .m_axi_arburst_o,
    .m_axi_awvalid_o, .m_axi_awready_i, .m_axi_wdata_o, .m_axi_wlast_o, .m_axi_wvalid_o, .m_axi_wready_i,
    .m_axi_bready_o, .m_axi_araddr_o, .m_axi_arlen_o, .m_axi_arvalid_o, .m_axi_arready_i,
    .m_axi_rvalid_i, .m_axi_rready_o);
`default_nettype wire
